/* File: hdl/dgr_map.svh */
`ifndef DGR_MAP_SVH
`define DGR_MAP_SVH
// Window size and decode
`define DGR_WIN_BYTES 4096
`define DGR_OFF_W 7
// Input configuration group
`define DGR_OFF_STATUS 7'h03
`define DGR_OFF_SERIAL 7'h05
`define DGR_OFF_STROBE 7'h0b
// Memory control group
`define DGR_OFF_TRAFFIC 7'h02
`define DGR_OFF_PULSE 7'h08
`define DGR_OFF_CHANNEL 7'h0a
`define DGR_OFF_DATA 7'h0c
`define DGR_OFF_MEMCTL 7'h21
`define DGR_OFF_PTR0 7'h23
`define DGR_OFF_PTR1 7'h25
`define DGR_OFF_PTR2 7'h27
`define DGR_OFF_ENDADR 7'h2b
`define DGR_OFF_START0 7'h2d
`define DGR_OFF_START1 7'h2f
// Arm and trigger group
`define DGR_OFF_ARMNOW 7'h41
`define DGR_OFF_ARMSTATE 7'h43
`define DGR_OFF_SMPTRIG 7'h45
`define DGR_OFF_ARMTRIG 7'h47
`define DGR_OFF_ARMSRC 7'h49
`define DGR_OFF_ARMCTL 7'h4b
`define DGR_OFF_TRIGSRC 7'h4d
`define DGR_OFF_REFOSC 7'h4f
`define DGR_OFF_ADLY_HI 7'h51
`define DGR_OFF_ADLY_LO 7'h53
`define DGR_OFF_ACNT_HI 7'h55
`define DGR_OFF_ACNT_LO 7'h57
`define DGR_OFF_ACNT_LAT 7'h59
`define DGR_OFF_TRIGNOW 7'h5d
`define DGR_OFF_TBRST 7'h5f
`define DGR_OFF_DECDIV 7'h61
`define DGR_OFF_BINDIV 7'h63
`define DGR_OFF_INTERP 7'h65
`define DGR_OFF_STOPDAT 7'h67
`define DGR_OFF_INTCAL 7'h69
`define DGR_OFF_SELFTEST 7'h6b
`define DGR_OFF_PRE_LO 7'h73
`define DGR_OFF_PRE_HI 7'h75
`define DGR_OFF_POST_LO 7'h77
`define DGR_OFF_POST_MID 7'h79
`define DGR_OFF_POST_HI 7'h7b
`define DGR_OFF_TBINIT_A 7'h7d
`define DGR_OFF_TBINIT_B 7'h7f
// Field positions
`define DGR_STROBE_BIT 2
`define DGR_ST_OVLD_LSB 4
`define DGR_ST_OVLCLR 2
`define DGR_ST_ERRLED 1
`define DGR_ST_SHOUT 0
// Reset value of every stored byte
`define DGR_RST_BYTE 8'h00
`endif

/* File: hdl/dgr_pkg.sv */
package dgr_pkg;
  // One register access from the controller
  typedef struct packed {
    logic sel;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dgr_bus_req_type;
  // Answer to one access
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } dgr_bus_rsp_type;
  // Access forwarded to timebase logic
  typedef struct packed {
    logic valid;
    logic wr;
    logic [6:0] offset;
    logic [7:0] data;
  } dgr_evt_type;
  // Assembled multi-byte timebase counts
  typedef struct packed {
    logic [15:0] arm_delay;
    logic [15:0] arm_count;
    logic [15:0] prearm;
    logic [23:0] postarm;
  } dgr_tb_type;
  // Read/write memory control bytes
  typedef struct packed {
    logic [7:0] traffic;
    logic [7:0] pulse;
    logic [7:0] channel;
    logic [7:0] data;
    logic [7:0] control;
    logic [7:0] end_addr;
    logic [15:0] start;
  } dgr_mem_type;
endpackage

/* File: hdl/dgr_regs.sv */
// Function
// - Input status at 0x03, read only
// - Status bit 0 shows shift bit 55
// - Status read never shifts the chain
// - Status carries overloads, clear, error bits
// - 0x05 reads and writes serial port
// - 0x0B write with bit 2 set strobes configuration out
// - Arm delay bytes at 0x51, 0x53
// - Arm count bytes 0x55/0x57, latch 0x59
// - Pre-arm count bytes at 0x73, 0x75
// - Post-arm bytes at 0x77, 0x79, 0x7B
// - Memory pointer readable at 0x23-0x27
// - Decode a 4096-byte window, byte wide
`timescale 1ns/1ps
`include "dgr_map.svh"
`default_nettype none

module dgr_regs #(
  parameter int SHIFT_W = 56
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register access
  input wire dgr_pkg::dgr_bus_req_type bus_req,
  output var dgr_pkg::dgr_bus_rsp_type bus_rsp_r,
  // Analog input section pins
  input wire logic [3:0] ovld_pin,
  input wire logic ovld_clr_pin,
  input wire logic err_led_pin,
  // Memory and arm logic, same clock
  input wire logic [23:0] mem_ptr,
  input wire logic [7:0] arm_state,
  // Converter configuration
  output logic [SHIFT_W-1:0] cfg_word_r,
  output logic cfg_load_r,
  // Timebase side
  output var dgr_pkg::dgr_tb_type tb_r,
  output logic count_latch_r,
  output var dgr_pkg::dgr_evt_type evt_r,
  // Memory control bytes
  output var dgr_pkg::dgr_mem_type mem_r
);

  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Offsets compare on the low seven bits only; the window
  // check above them is done once, in the address decode.

  // True when the window offset equals a register offset
  function automatic logic hit(
    input logic [`DGR_OFF_W-1:0] off,
    input logic [`DGR_OFF_W-1:0] reg_off
  );
    hit = (off == reg_off);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Pins from the analog section change at any time; two flops
  // keep a metastable level away from the status read path.

  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;

  // Two stages; only the second stage is read by logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end else begin
      pin_meta_r <= {ovld_pin, ovld_clr_pin, err_led_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire logic [3:0] ovld_s = pin_sync_r[5:2];
  wire logic ovld_clr_s = pin_sync_r[1];
  wire logic err_led_s = pin_sync_r[0];

  ////////////////////////////////////////////////////////////////////
  // Address decode
  // Accesses above the register area are still acknowledged, so
  // a controller probing the window never sees a bus error.

  // Only the low 128 bytes of the window hold registers
  wire logic in_win = (bus_req.addr[11:7] == 5'h00);
  wire logic [6:0] off = bus_req.addr[6:0];
  wire logic acc = bus_req.sel;
  wire logic wr = acc && bus_req.wr && in_win;
  wire logic rd = acc && !bus_req.wr && in_win;
  wire logic [7:0] wd = bus_req.wdata;

  // Input configuration group
  wire logic rd_status = rd && hit(off, `DGR_OFF_STATUS);
  wire logic rd_serial = rd && hit(off, `DGR_OFF_SERIAL);
  wire logic wr_serial = wr && hit(off, `DGR_OFF_SERIAL);
  wire logic wr_strobe = wr && hit(off, `DGR_OFF_STROBE);

  // Memory control group, read/write
  wire logic hit_traf = hit(off, `DGR_OFF_TRAFFIC);
  wire logic hit_puls = hit(off, `DGR_OFF_PULSE);
  wire logic hit_chan = hit(off, `DGR_OFF_CHANNEL);
  wire logic hit_data = hit(off, `DGR_OFF_DATA);
  wire logic hit_mctl = hit(off, `DGR_OFF_MEMCTL);
  wire logic hit_enda = hit(off, `DGR_OFF_ENDADR);
  wire logic hit_st0 = hit(off, `DGR_OFF_START0);
  wire logic hit_st1 = hit(off, `DGR_OFF_START1);

  // Memory control write strobes
  wire logic wr_traf = wr && hit_traf;
  wire logic wr_puls = wr && hit_puls;
  wire logic wr_chan = wr && hit_chan;
  wire logic wr_data = wr && hit_data;
  wire logic wr_mctl = wr && hit_mctl;
  wire logic wr_enda = wr && hit_enda;
  wire logic wr_st0 = wr && hit_st0;
  wire logic wr_st1 = wr && hit_st1;

  // Arm and trigger counts, write only
  wire logic wr_adly_hi = wr && hit(off, `DGR_OFF_ADLY_HI);
  wire logic wr_adly_lo = wr && hit(off, `DGR_OFF_ADLY_LO);
  wire logic wr_acnt_hi = wr && hit(off, `DGR_OFF_ACNT_HI);
  wire logic wr_acnt_lo = wr && hit(off, `DGR_OFF_ACNT_LO);
  wire logic wr_acnt_lat = wr && hit(off, `DGR_OFF_ACNT_LAT);
  wire logic wr_pre_lo = wr && hit(off, `DGR_OFF_PRE_LO);
  wire logic wr_pre_hi = wr && hit(off, `DGR_OFF_PRE_HI);
  wire logic wr_post_lo = wr && hit(off, `DGR_OFF_POST_LO);
  wire logic wr_post_mid = wr && hit(off, `DGR_OFF_POST_MID);
  wire logic wr_post_hi = wr && hit(off, `DGR_OFF_POST_HI);

  // Timebase locations, one named decode each
  wire logic hit_armnow = hit(off, `DGR_OFF_ARMNOW);
  wire logic hit_armstate = hit(off, `DGR_OFF_ARMSTATE);
  wire logic hit_smptrig = hit(off, `DGR_OFF_SMPTRIG);
  wire logic hit_armtrig = hit(off, `DGR_OFF_ARMTRIG);
  wire logic hit_armsrc = hit(off, `DGR_OFF_ARMSRC);
  wire logic hit_armctl = hit(off, `DGR_OFF_ARMCTL);
  wire logic hit_trigsrc = hit(off, `DGR_OFF_TRIGSRC);
  wire logic hit_refosc = hit(off, `DGR_OFF_REFOSC);
  wire logic hit_trignow = hit(off, `DGR_OFF_TRIGNOW);
  wire logic hit_tbrst = hit(off, `DGR_OFF_TBRST);
  wire logic hit_decdiv = hit(off, `DGR_OFF_DECDIV);
  wire logic hit_bindiv = hit(off, `DGR_OFF_BINDIV);
  wire logic hit_interp = hit(off, `DGR_OFF_INTERP);
  wire logic hit_stopdat = hit(off, `DGR_OFF_STOPDAT);
  wire logic hit_intcal = hit(off, `DGR_OFF_INTCAL);
  wire logic hit_selftest = hit(off, `DGR_OFF_SELFTEST);
  wire logic hit_tbinit_a = hit(off, `DGR_OFF_TBINIT_A);
  wire logic hit_tbinit_b = hit(off, `DGR_OFF_TBINIT_B);

  // Timebase locations that the timebase logic acts on itself;
  // the read-only arm state location passes on too, harmlessly
  wire logic tb_loc =
    hit_armnow ||
    hit_armstate ||
    hit_smptrig ||
    hit_armtrig ||
    hit_armsrc ||
    hit_armctl ||
    hit_trigsrc ||
    hit_refosc ||
    hit_trignow ||
    hit_tbrst ||
    hit_decdiv ||
    hit_bindiv ||
    hit_interp ||
    hit_stopdat ||
    hit_intcal ||
    hit_selftest ||
    hit_tbinit_a ||
    hit_tbinit_b;

  // Reads of the two mixed read/write locations also carry meaning
  wire logic tb_rd_loc = hit_armnow || hit_smptrig;
  wire logic evt_fire = (wr && tb_loc) || (rd && tb_rd_loc);

  ////////////////////////////////////////////////////////////////////
  // Configuration shift chain
  // Holds the converter setup as it is assembled, one bit per serial
  // write; the converter only sees it after a strobe.

  logic [SHIFT_W-1:0] shift_r;
  logic [SHIFT_W-1:0] shift_nxt;
  wire logic shift_out = shift_r[SHIFT_W-1];

  // A serial write enters at bit 0; a serial read moves the chain
  // one place and feeds the top bit back in, so 56 reads restore it.
  // A status read is absent here on purpose: it must not move it.
  always_comb begin
    shift_nxt = shift_r;
    if (wr_serial) begin
      shift_nxt = {shift_r[SHIFT_W-2:0], wd[0]};
    end else if (rd_serial) begin
      shift_nxt = {shift_r[SHIFT_W-2:0], shift_out};
    end
  end

  // Chain storage; untouched by status reads
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Parallel strobe copies the chain to the converter
  wire logic strobe_go = wr_strobe && wd[`DGR_STROBE_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_word_r <= '0;
      cfg_load_r <= 1'b0;
    end else begin
      cfg_load_r <= strobe_go;
      if (strobe_go) begin
        cfg_word_r <= shift_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timebase counts
  // Each count is a plain register per byte; nothing here counts
  // down, that is left to the timebase logic that reads them.

  logic [15:0] arm_delay_r;
  logic [15:0] arm_count_r;
  logic [15:0] prearm_r;
  logic [23:0] postarm_r;

  // Byte halves collect independently; the far side reads the
  // assembled word, so it should wait until all bytes are written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_delay_r <= '0;
    end else begin
      if (wr_adly_hi) arm_delay_r[15:8] <= wd;
      if (wr_adly_lo) arm_delay_r[7:0] <= wd;
    end
  end

  // Arm count bytes; the latch strobe below is separate
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_count_r <= '0;
    end else begin
      if (wr_acnt_hi) arm_count_r[15:8] <= wd;
      if (wr_acnt_lo) arm_count_r[7:0] <= wd;
    end
  end

  // Pre-arm reading count, low byte first in the map
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prearm_r <= '0;
    end else begin
      if (wr_pre_lo) prearm_r[7:0] <= wd;
      if (wr_pre_hi) prearm_r[15:8] <= wd;
    end
  end

  // Post-arm reading count, three bytes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      postarm_r <= '0;
    end else begin
      if (wr_post_lo) postarm_r[7:0] <= wd;
      if (wr_post_mid) postarm_r[15:8] <= wd;
      if (wr_post_hi) postarm_r[23:16] <= wd;
    end
  end

  // Latch strobe is a one-cycle pulse; any written value fires it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_latch_r <= 1'b0;
    end else begin
      count_latch_r <= wr_acnt_lat;
    end
  end

  // Counts leave as one bundle, wired straight from the flops
  assign tb_r = {arm_delay_r, arm_count_r, prearm_r, postarm_r};

  // Other timebase locations pass on as a one-cycle event
  // Side fields follow every access; only valid marks a real one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_r <= '0;
    end else begin
      evt_r.valid <= evt_fire;
      evt_r.wr <= bus_req.wr;
      evt_r.offset <= off;
      evt_r.data <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory control bytes
  // Only the stored values live here; the memory sequencer that
  // acts on them sits outside this block.

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_r <= '0;
    end else begin
      if (wr_traf) mem_r.traffic <= wd;
      if (wr_puls) mem_r.pulse <= wd;
      if (wr_chan) mem_r.channel <= wd;
      if (wr_data) mem_r.data <= wd;
      if (wr_mctl) mem_r.control <= wd;
      if (wr_enda) mem_r.end_addr <= wd;
      if (wr_st0) mem_r.start[7:0] <= wd;
      if (wr_st1) mem_r.start[15:8] <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data
  // Read data is registered with the acknowledge, so both change on
  // the same edge and the controller never sees a half answer.

  // Status byte; bit 3 unused reads zero. The overload bits are live
  // levels, not sticky, so a brief overload can be missed by a poll.
  wire logic st_unused = 1'b0;
  wire logic [7:0] status_byte = {
    ovld_s,
    st_unused,
    ovld_clr_s,
    err_led_s,
    shift_out
  };

  logic [7:0] rdata_nxt;

  // Write-only and unmapped offsets read zero. Writes to the status
  // and pointer locations fall through every decode above and change nothing.
  always_comb begin
    rdata_nxt = `DGR_RST_BYTE;
    if (rd) begin
      case (off)
        `DGR_OFF_STATUS: rdata_nxt = status_byte;
        `DGR_OFF_SERIAL: rdata_nxt = {7'h00, shift_out};
        `DGR_OFF_TRAFFIC: rdata_nxt = mem_r.traffic;
        `DGR_OFF_PULSE: rdata_nxt = mem_r.pulse;
        `DGR_OFF_CHANNEL: rdata_nxt = mem_r.channel;
        `DGR_OFF_DATA: rdata_nxt = mem_r.data;
        `DGR_OFF_MEMCTL: rdata_nxt = mem_r.control;
        `DGR_OFF_PTR0: rdata_nxt = mem_ptr[7:0];
        `DGR_OFF_PTR1: rdata_nxt = mem_ptr[15:8];
        `DGR_OFF_PTR2: rdata_nxt = mem_ptr[23:16];
        `DGR_OFF_ENDADR: rdata_nxt = mem_r.end_addr;
        `DGR_OFF_START0: rdata_nxt = mem_r.start[7:0];
        `DGR_OFF_START1: rdata_nxt = mem_r.start[15:8];
        `DGR_OFF_ARMSTATE: rdata_nxt = arm_state;
        default: rdata_nxt = `DGR_RST_BYTE;
      endcase
    end
  end

  // Every access is answered one cycle later, mapped or not
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rsp_r <= '0;
    end else begin
      bus_rsp_r.ack <= acc;
      bus_rsp_r.rdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: sim/dgr_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dgr_regs_assertions #(
  parameter int SHIFT_W = 56
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register access
  input wire dgr_pkg::dgr_bus_req_type bus_req,
  input wire dgr_pkg::dgr_bus_rsp_type bus_rsp_r,
  // Status and pointer inputs
  input wire logic [3:0] ovld_pin,
  input wire logic ovld_clr_pin,
  input wire logic err_led_pin,
  input wire logic [23:0] mem_ptr,
  input wire logic [7:0] arm_state,
  // Outputs under watch
  input wire logic [SHIFT_W-1:0] cfg_word_r,
  input wire logic cfg_load_r,
  input wire dgr_pkg::dgr_tb_type tb_r,
  input wire logic count_latch_r,
  input wire dgr_pkg::dgr_evt_type evt_r,
  input wire dgr_pkg::dgr_mem_type mem_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////
  // Decoded request kinds
  wire logic rd = bus_req.sel && !bus_req.wr;
  wire logic wr = bus_req.sel && bus_req.wr;
  wire logic [11:0] ad = bus_req.addr;
  wire logic stb = wr && ad == 12'h00b && bus_req.wdata[2];
  ////////////////////////////////
  property p_ack; bus_req.sel |=> bus_rsp_r.ack; endproperty
  a_ack: assert property (p_ack)
    else $error("ack missing after access");
  property p_no_ack; !bus_req.sel |=> !bus_rsp_r.ack; endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("ack without access");
  property p_st_gap; rd && ad == 12'h003 |=> !bus_rsp_r.rdata[3]; endproperty
  a_st_gap: assert property (p_st_gap)
    else $error("status unused bit set");
  property p_wo_zero; rd && ad[11:4] == 8'h05 |=> bus_rsp_r.rdata == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only read not zero");
  property p_ptr;
    rd && ad == 12'h027 |=> bus_rsp_r.rdata == $past(mem_ptr[23:16]);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer top byte wrong");
  property p_strobe; stb |=> cfg_load_r; endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe did not load");
  property p_no_strobe; !stb |=> !cfg_load_r; endproperty
  a_no_strobe: assert property (p_no_strobe)
    else $error("load without strobe");
  property p_latch; wr && ad == 12'h059 |=> count_latch_r; endproperty
  a_latch: assert property (p_latch)
    else $error("count latch missing");
  property p_dly;
    wr && ad == 12'h051 |=> tb_r.arm_delay[15:8] == $past(bus_req.wdata);
  endproperty
  a_dly: assert property (p_dly)
    else $error("delay high byte wrong");
  property p_evt;
    wr && ad == 12'h041 |=> evt_r.valid && evt_r.wr;
  endproperty
  a_evt: assert property (p_evt)
    else $error("abort write gave no event");
  property p_evt_rd;
    rd && ad == 12'h045 |=> evt_r.valid && !evt_r.wr;
  endproperty
  a_evt_rd: assert property (p_evt_rd)
    else $error("trigger read gave no event");
  property p_ser;
    rd && ad == 12'h005 |=> bus_rsp_r.rdata[7:1] == 7'h00;
  endproperty
  a_ser: assert property (p_ser)
    else $error("serial read upper bits set");
  // Main scenarios reached
  c_strobe: cover property (stb);
  c_status: cover property (rd && ad == 12'h003);
  c_latch: cover property (wr && ad == 12'h059);
  c_event: cover property (evt_r.valid);
endmodule
bind dgr_regs dgr_regs_assertions #(.SHIFT_W(SHIFT_W)) dgr_regs_assertions_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rsp_r(bus_rsp_r), .ovld_pin(ovld_pin), .ovld_clr_pin(ovld_clr_pin),
  .err_led_pin(err_led_pin), .mem_ptr(mem_ptr), .arm_state(arm_state),
  .cfg_word_r(cfg_word_r), .cfg_load_r(cfg_load_r), .tb_r(tb_r),
  .count_latch_r(count_latch_r), .evt_r(evt_r), .mem_r(mem_r));
`default_nettype wire

/* File: sim/dgr_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dgr_ctl_model (
  // Clock
  input wire logic sys_clk,
  // Register access
  output var dgr_pkg::dgr_bus_req_type bus_req,
  input wire dgr_pkg::dgr_bus_rsp_type bus_rsp
);
  initial bus_req = '0;
  // One byte access: request one cycle, answer taken a cycle later
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic k);
    @(posedge sys_clk);
    #2 bus_req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge sys_clk);
    // Released lines show junk so stale values are never trusted
    #2 bus_req = '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
    q = bus_rsp.rdata;
    k = bus_rsp.ack;
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [11:0] a; logic [7:0] d;} dgr_row_type;
  logic sys_clk;
  logic rst_b;
  dgr_pkg::dgr_bus_req_type bus_req;
  dgr_pkg::dgr_bus_rsp_type bus_rsp;
  logic [3:0] ovld_pin;
  logic ovld_clr_pin;
  logic err_led_pin;
  logic [23:0] mem_ptr;
  logic [7:0] arm_state;
  logic [55:0] cfg_word;
  logic cfg_load;
  logic count_latch;
  dgr_pkg::dgr_tb_type tb;
  dgr_pkg::dgr_evt_type evt;
  dgr_pkg::dgr_mem_type mem;
  int num_errors;
  int tests_run;
  int cyc;
  logic [7:0] q;
  logic k;
  dgr_row_type rows [8] = '{'{12'h002, 8'h5a}, '{12'h008, 8'ha5},
    '{12'h00a, 8'h3c}, '{12'h00c, 8'hc3}, '{12'h021, 8'h96},
    '{12'h02b, 8'h69}, '{12'h02d, 8'h0f}, '{12'h02f, 8'hf0}};
  logic [11:0] tba [9] = '{12'h051, 12'h053, 12'h055, 12'h057, 12'h073,
    12'h075, 12'h077, 12'h079, 12'h07b};
  ////////////////////////////////
  dgr_regs dgr_regs_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rsp_r(bus_rsp), .ovld_pin(ovld_pin), .ovld_clr_pin(ovld_clr_pin),
    .err_led_pin(err_led_pin), .mem_ptr(mem_ptr), .arm_state(arm_state),
    .cfg_word_r(cfg_word), .cfg_load_r(cfg_load), .tb_r(tb),
    .count_latch_r(count_latch), .evt_r(evt), .mem_r(mem));
  dgr_ctl_model dgr_ctl_model_i (.sys_clk(sys_clk), .bus_req(bus_req),
    .bus_rsp(bus_rsp));
  ////////////////////////////////
  // Shared compare, read and write steps
  task automatic chk(input string n, input logic [71:0] s,
    input logic [71:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    dgr_ctl_model_i.acc(1'b0, a, 8'h00, q, k);
    chk(n, {63'h0, k, q}, {63'h0, 1'b1, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    dgr_ctl_model_i.acc(1'b1, a, d, q, k);
    chk("write ack", {71'h0, k}, 72'h1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Clock and a hang guard well past the few hundred cycles used
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ovld_pin = 4'ha;
    ovld_clr_pin = 1'b1;
    err_led_pin = 1'b0;
    mem_ptr = 24'h3c2a19;
    arm_state = 8'hc3;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    chk("reset counts", tb, 72'h0);
    chk("reset answer", {63'h0, bus_rsp}, 72'h0);
    $display("done: reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].d, "rw byte");
    end
    chk("mem bytes", {8'h0, mem}, 72'h5aa53cc39669f00f);
    $display("done: rw bytes");
    foreach (tba[i]) wr(tba[i], tba[i][7:0]);
    chk("arm delay", {56'h0, tb.arm_delay}, 72'h5153);
    chk("arm count", {56'h0, tb.arm_count}, 72'h5557);
    chk("pre-arm", {56'h0, tb.prearm}, 72'h7573);
    chk("post-arm", {48'h0, tb.postarm}, 72'h7b7977);
    wr(12'h059, 8'h00);
    chk("latch", {71'h0, count_latch}, 72'h1);
    rd(12'h051, 8'h00, "wo read");
    chk("no event", {71'h0, evt.valid}, 72'h0);
    rd(12'h080, 8'h00, "unmapped");
    rd(12'hfff, 8'h00, "window top");
    wr(12'h023, 8'hff);
    rd(12'h023, 8'h19, "ptr0");
    rd(12'h025, 8'h2a, "ptr1");
    rd(12'h027, 8'h3c, "ptr2");
    rd(12'h043, 8'hc3, "arm state");
    wr(12'h041, 8'h3c);
    chk("abort event", {55'h0, evt}, {55'h0, 2'h3, 7'h41, 8'h3c});
    rd(12'h045, 8'h00, "trig read");
    chk("trig event", {55'h0, evt}, {55'h0, 2'h2, 7'h45, 8'h00});
    $display("done: decode");
    // First bit written must reach the output stage
    for (int i = 0; i < 56; i++) begin
      wr(12'h005, (i == 0) ? 8'h01 : 8'h00);
    end
    rd(12'h003, 8'ha5, "status");
    wr(12'h003, 8'h00);
    rd(12'h003, 8'ha5, "status kept");
    wr(12'h00b, 8'hfb);
    chk("no load", {15'h0, cfg_load, cfg_word}, 72'h0);
    wr(12'h00b, 8'h04);
    chk("load", {15'h0, cfg_load, cfg_word}, {16'h1, 56'h80 << 48});
    rd(12'h005, 8'h01, "serial out");
    rd(12'h003, 8'ha4, "after shift");
    $display("done: shift chain");
    rst_b = 1'b0;
    #1 chk("mid reset tb", tb, 72'h0);
    chk("mid reset mem", {8'h0, mem}, 72'h0);
    @(posedge sys_clk);
    #2 rst_b = 1'b1;
    rd(12'h002, 8'h00, "traffic cleared");
    $display("done: mid reset");
    wrap_up();
  end
endmodule
`default_nettype wire
